// ### verilog/uhr_pkg.sv
// shared constants and types of the hid report and command unit
package uhr_pkg;
	// usb report identifiers
	localparam logic [7:0] RID_MEM      = 8'h01;
	localparam logic [7:0] RID_DBG2     = 8'h02;
	localparam logic [7:0] RID_STY      = 8'h03;
	localparam logic [7:0] RID_TCH      = 8'h01;
	// command codes in data byte 1
	localparam logic [7:0] CMD_NULL     = 8'h00;
	localparam logic [7:0] CMD_MEM      = 8'h01;
	localparam logic [7:0] CMD_AUTO     = 8'h02;
	localparam logic [7:0] CMD_DBG_GO   = 8'h03;
	localparam logic [7:0] CMD_DBG_STOP = 8'h04;
	// tags in byte 1 of message and debug packets
	localparam logic [7:0] TAG_MSG      = 8'h05;
	localparam logic [7:0] TAG_DBG      = 8'h06;
	// memory access status
	localparam logic [7:0] ST_OK        = 8'h00;
	localparam logic [7:0] ST_WR_ONLY   = 8'h04;
	// endpoints
	localparam logic [3:0] EP_RSP       = 4'h1;
	localparam logic [3:0] EP_CMD       = 4'h2;
	localparam logic [3:0] EP_DIG       = 4'h3;
	// packet layout
	localparam logic [6:0] PKT_LEN      = 7'h40;
	localparam logic [5:0] PKT_LAST     = 6'h3f;
	localparam int         POS_ID       = 0;
	localparam int         POS_CMD      = 1;
	localparam int         POS_NRX      = 2;
	localparam int         POS_NWX      = 3;
	localparam int         POS_ALO      = 4;
	localparam int         POS_AHI      = 5;
	localparam logic [5:0] HDR_LEN      = 6'h06;
	localparam logic [7:0] ADDR_LEN     = 8'h02;
	localparam logic [7:0] MAX_WR       = 8'h3a;
	localparam logic [7:0] MAX_RD       = 8'h3d;
	localparam logic [5:0] RD_BASE      = 6'h03;
	// touch report layout
	localparam int         TCH_N        = 5;
	localparam int         TCH_STRIDE   = 11;
	localparam int         TCH_TIME_POS = 56;
	localparam int         TCH_CNT_POS  = 58;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX   = 6'h02,
		ST_DEC  = 6'h04,
		ST_WR   = 6'h08,
		ST_RD   = 6'h10,
		ST_TX   = 6'h20
	} uhr_state_t;

	typedef logic [63:0][7:0] uhr_pkt_t;
endpackage

// ### verilog/uhr_fmt_if.sv
// report formatter signals between the unit and its formatter
`timescale 1ns/1ps
`default_nettype none
interface uhr_fmt_if;
	logic                 is_sty;
	logic                 geom;
	logic [4:0]           t_stat;
	logic [4:0][11:0]     t_x;
	logic [4:0][11:0]     t_xc;
	logic [4:0][11:0]     t_y;
	logic [4:0][11:0]     t_yc;
	logic [4:0][7:0]      t_w;
	logic [4:0][7:0]      t_h;
	logic [15:0]          t_time;
	logic [7:0]           t_cnt;
	logic [3:0]           s_flags;
	logic [15:0]          s_x;
	logic [15:0]          s_xc;
	logic [15:0]          s_y;
	logic [15:0]          s_yc;
	logic [7:0]           s_prs;
	uhr_pkg::uhr_pkt_t    img;
	modport src (output is_sty, geom, t_stat, t_x, t_xc, t_y, t_yc, t_w, t_h,
		t_time, t_cnt, s_flags, s_x, s_xc, s_y, s_yc, s_prs, input img);
	modport fmt (input is_sty, geom, t_stat, t_x, t_xc, t_y, t_yc, t_w, t_h,
		t_time, t_cnt, s_flags, s_x, s_xc, s_y, s_yc, s_prs, output img);
endinterface
`default_nettype wire

// ### verilog/uhr_fmt.sv
// touch and stylus report image builder
`timescale 1ns/1ps
`default_nettype none
module uhr_fmt (
	uhr_fmt_if.fmt f
);
	uhr_pkg::uhr_pkt_t img;

	always_comb begin
		img = '0;
		if (f.is_sty) begin
			img[0] = uhr_pkg::RID_STY;
			img[1] = {3'h0, f.s_flags[3], 1'b0, f.s_flags[2:0]};
			{img[3], img[2]} = f.s_x;
			{img[5], img[4]} = f.s_xc;
			{img[7], img[6]} = f.s_y;
			{img[9], img[8]} = f.s_yc;
			img[10] = f.s_prs;
		end else begin
			img[0] = uhr_pkg::RID_TCH;
			for (int k = 0; k < uhr_pkg::TCH_N; k++) begin
				// slot k reports as touch k+1, never zero
				img[k*uhr_pkg::TCH_STRIDE+1] = {5'(k + 1), 2'h0, f.t_stat[k]};
				{img[k*uhr_pkg::TCH_STRIDE+3], img[k*uhr_pkg::TCH_STRIDE+2]} =
					{4'h0, f.t_x[k]};
				{img[k*uhr_pkg::TCH_STRIDE+7], img[k*uhr_pkg::TCH_STRIDE+6]} =
					{4'h0, f.t_y[k]};
				if (f.geom) begin
					{img[k*uhr_pkg::TCH_STRIDE+5], img[k*uhr_pkg::TCH_STRIDE+4]} =
						{4'h0, f.t_xc[k]};
					{img[k*uhr_pkg::TCH_STRIDE+9], img[k*uhr_pkg::TCH_STRIDE+8]} =
						{4'h0, f.t_yc[k]};
					img[k*uhr_pkg::TCH_STRIDE+10] = f.t_w[k];
					img[k*uhr_pkg::TCH_STRIDE+11] = f.t_h[k];
				end
			end
			{img[uhr_pkg::TCH_TIME_POS+1], img[uhr_pkg::TCH_TIME_POS]} = f.t_time;
			img[uhr_pkg::TCH_CNT_POS] = f.t_cnt;
		end
	end

	assign f.img = img;
endmodule
`default_nettype wire

// ### verilog/uhr_top.sv
// hid report formatter and generic command interpreter
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uhr_top #(
	parameter int MSG_BYTES = 10
) (
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	input  wire logic                      rx_valid,
	input  wire logic [7:0]                rx_data,
	input  wire logic                      rx_last,
	input  wire logic [3:0]                rx_ep,
	output logic                           rx_ready,
	output logic                           tx_valid,
	output logic [7:0]                     tx_data,
	output logic                           tx_last,
	output logic [3:0]                     tx_ep,
	input  wire logic                      tx_ready,
	output logic [15:0]                    mem_addr,
	output logic [7:0]                     mem_wdata,
	output logic                           mem_we,
	output logic                           mem_re,
	input  wire logic [7:0]                mem_rdata,
	input  wire logic                      geometry_calc_enable,
	input  wire logic                      tch_valid,
	input  wire logic                      tch_first,
	input  wire logic [7:0]                tch_count,
	input  wire logic [15:0]               tch_time,
	input  wire logic [4:0]                tch_stat,
	input  wire logic [4:0][11:0]          tch_x,
	input  wire logic [4:0][11:0]          tch_xc,
	input  wire logic [4:0][11:0]          tch_y,
	input  wire logic [4:0][11:0]          tch_yc,
	input  wire logic [4:0][7:0]           tch_w,
	input  wire logic [4:0][7:0]           tch_h,
	output logic                           tch_taken,
	input  wire logic                      sty_valid,
	input  wire logic [3:0]                sty_flags,
	input  wire logic [15:0]               sty_x,
	input  wire logic [15:0]               sty_xc,
	input  wire logic [15:0]               sty_y,
	input  wire logic [15:0]               sty_yc,
	input  wire logic [7:0]                sty_prs,
	output logic                           sty_taken,
	input  wire logic                      msg_valid,
	input  wire logic [7:0]                object_report_identifier,
	input  wire logic [MSG_BYTES-1:0][7:0] msg_data,
	output logic                           msg_taken,
	input  wire logic                      dbg_valid,
	input  wire logic [7:0]                debug_packet_index,
	input  wire logic [7:0]                debug_packet_total,
	input  wire logic [7:0]                debug_frame_number,
	input  wire logic [58:0][7:0]          dbg_data,
	output logic                           dbg_taken,
	output logic                           auto_return_on,
	output logic                           debug_mon_on
);
	function automatic logic [7:0] pkt_byte(input uhr_pkg::uhr_pkt_t b,
			input logic [6:0] n, input int i);
		// bytes past a short packet read as zero
		return (7'(i) < n) ? b[i] : 8'h00;
	endfunction

	function automatic logic [5:0] clamp(input logic [7:0] v, input logic [7:0] m);
		return (v > m) ? m[5:0] : v[5:0];
	endfunction

	uhr_pkg::uhr_state_t state_reg;
	uhr_pkg::uhr_pkt_t   cmd_reg;
	uhr_pkg::uhr_pkt_t   tx_img_reg;
	logic [6:0]          rx_cnt_reg;
	logic                rx_ready_reg;
	logic [15:0]         ptr_reg;
	logic [5:0]          wr_left_reg;
	logic [5:0]          wr_pos_reg;
	logic [5:0]          rd_left_reg;
	logic [5:0]          rd_slot_reg;
	logic                re_d_reg;
	logic [15:0]         mem_addr_reg;
	logic [7:0]          mem_wdata_reg;
	logic                mem_we_reg;
	logic                mem_re_reg;
	logic                tx_valid_reg;
	logic [7:0]          tx_data_reg;
	logic                tx_last_reg;
	logic [3:0]          tx_ep_reg;
	logic [5:0]          tx_idx_reg;
	logic                auto_reg;
	logic                dbg_on_reg;
	logic [7:0]          dbg_id_reg;
	logic [15:0]         time_reg;
	logic                tch_taken_reg;
	logic                sty_taken_reg;
	logic                msg_taken_reg;
	logic                dbg_taken_reg;

	uhr_fmt_if fif ();

	uhr_fmt u_fmt (
		.f (fif.fmt)
	);

	wire logic st_idle = (state_reg == uhr_pkg::ST_IDLE);
	wire logic st_rx   = (state_reg == uhr_pkg::ST_RX);
	wire logic st_dec  = (state_reg == uhr_pkg::ST_DEC);
	wire logic st_wr   = (state_reg == uhr_pkg::ST_WR);
	wire logic st_rd   = (state_reg == uhr_pkg::ST_RD);
	wire logic st_tx   = (state_reg == uhr_pkg::ST_TX);

	// command decode, header of six bytes
	wire logic [7:0]  c_id   = pkt_byte(cmd_reg, rx_cnt_reg, uhr_pkg::POS_ID);
	wire logic [7:0]  c_cmd  = pkt_byte(cmd_reg, rx_cnt_reg, uhr_pkg::POS_CMD);
	wire logic [7:0]  c_nrx  = pkt_byte(cmd_reg, rx_cnt_reg, uhr_pkg::POS_NRX);
	wire logic [7:0]  c_nwx  = pkt_byte(cmd_reg, rx_cnt_reg, uhr_pkg::POS_NWX);
	wire logic [15:0] c_addr = {pkt_byte(cmd_reg, rx_cnt_reg, uhr_pkg::POS_AHI),
		pkt_byte(cmd_reg, rx_cnt_reg, uhr_pkg::POS_ALO)};
	wire logic        is_mem   = (c_cmd == uhr_pkg::CMD_MEM);
	wire logic        has_addr = (c_nwx >= uhr_pkg::ADDR_LEN);
	// pointer bytes counted in the write count, surplus data dropped
	wire logic [5:0]  n_wr = has_addr ? clamp(c_nwx - uhr_pkg::ADDR_LEN, uhr_pkg::MAX_WR) : 6'h00;
	wire logic [5:0]  n_rd = clamp(c_nrx, uhr_pkg::MAX_RD);
	wire logic [7:0]  rsp_stat = (c_nrx == 8'h00) ? uhr_pkg::ST_WR_ONLY : uhr_pkg::ST_OK;
	// memory answer echoes the requested count
	wire uhr_pkg::uhr_pkt_t rsp_img = is_mem ? 512'({c_nrx, rsp_stat, c_id}) :
		512'({c_cmd, c_id});

	// receive handshake; only endpoint 2 opens a command
	wire logic rx_take  = rx_valid & rx_ready_reg;
	wire logic rx_start = st_idle & rx_take & (rx_ep == uhr_pkg::EP_CMD);
	wire logic rx_more  = st_rx & rx_take;
	wire logic rx_end   = (rx_start | rx_more) & rx_last;

	// autonomous sources, debug first, then messages, stylus, touch
	wire logic sel_dbg = dbg_valid & dbg_on_reg;
	wire logic sel_msg = ~sel_dbg & msg_valid & auto_reg;
	wire logic sel_sty = ~sel_dbg & ~sel_msg & sty_valid;
	wire logic sel_tch = ~sel_dbg & ~sel_msg & ~sty_valid & tch_valid;
	// a pending command goes before any report, except in the first cycle after reset
	wire logic launch  = st_idle & ~rx_start & (sel_dbg | sel_msg | sel_sty | sel_tch);

	// debug packet: index, total, frame, then 59 data bytes
	wire uhr_pkg::uhr_pkt_t dbg_img = {dbg_data, debug_frame_number, debug_packet_total,
		debug_packet_index, uhr_pkg::TAG_DBG, dbg_id_reg};
	wire uhr_pkg::uhr_pkt_t msg_img = 512'({msg_data, object_report_identifier,
		uhr_pkg::TAG_MSG, uhr_pkg::RID_MEM});
	wire uhr_pkg::uhr_pkt_t src_img = sel_dbg ? dbg_img : (sel_msg ? msg_img : fif.img);
	wire logic [3:0] src_ep = (sel_dbg | sel_msg) ? uhr_pkg::EP_RSP : uhr_pkg::EP_DIG;

	wire logic wr_go   = st_wr & (wr_left_reg != 6'h00);
	wire logic rd_go   = st_rd & (rd_left_reg != 6'h00);
	wire logic rd_done = st_rd & (rd_left_reg == 6'h00) & ~mem_re_reg & ~re_d_reg;
	wire logic tx_beat = st_tx & tx_valid_reg & tx_ready;
	wire logic tx_done = tx_beat & tx_last_reg;

	assign fif.is_sty  = sel_sty;
	assign fif.geom    = geometry_calc_enable;
	assign fif.t_stat  = tch_stat;
	assign fif.t_x     = tch_x;
	assign fif.t_xc    = tch_xc;
	assign fif.t_y     = tch_y;
	assign fif.t_yc    = tch_yc;
	assign fif.t_w     = tch_w;
	assign fif.t_h     = tch_h;
	// later packets of a frame reuse the first packet's time
	assign fif.t_time  = tch_first ? tch_time : time_reg;
	assign fif.t_cnt   = tch_first ? tch_count : 8'h00;
	assign fif.s_flags = sty_flags;
	assign fif.s_x     = sty_x;
	assign fif.s_xc    = sty_xc;
	assign fif.s_y     = sty_y;
	assign fif.s_yc    = sty_yc;
	assign fif.s_prs   = sty_prs;

	// sequencer; new bytes are refused while a command is served
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_reg    <= uhr_pkg::ST_IDLE;
			rx_ready_reg <= 1'b0;
		end else begin
			rx_ready_reg <= (st_idle & ~launch & ~rx_end) | (st_rx & ~rx_end) | tx_done;
			unique case (state_reg)
				uhr_pkg::ST_IDLE: begin
					if (rx_start)
						state_reg <= rx_last ? uhr_pkg::ST_DEC : uhr_pkg::ST_RX;
					else if (launch)
						state_reg <= uhr_pkg::ST_TX;
				end
				uhr_pkg::ST_RX: begin
					if (rx_end)
						state_reg <= uhr_pkg::ST_DEC;
				end
				uhr_pkg::ST_DEC: begin
					state_reg <= is_mem ? uhr_pkg::ST_WR : uhr_pkg::ST_TX;
				end
				uhr_pkg::ST_WR: begin
					if (!wr_go)
						state_reg <= uhr_pkg::ST_RD;
				end
				uhr_pkg::ST_RD: begin
					if (rd_done)
						state_reg <= uhr_pkg::ST_TX;
				end
				uhr_pkg::ST_TX: begin
					if (tx_done)
						state_reg <= uhr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// bytes past 64 are dropped
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rx_cnt_reg <= 7'h00;
			cmd_reg    <= '0;
		end else if (rx_start) begin
			rx_cnt_reg <= 7'h01;
			cmd_reg[0] <= rx_data;
		end else if (rx_more && rx_cnt_reg < uhr_pkg::PKT_LEN) begin
			rx_cnt_reg              <= rx_cnt_reg + 7'h01;
			cmd_reg[rx_cnt_reg[5:0]] <= rx_data;
		end
	end

	// memory map master, pointer kept across commands
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ptr_reg     <= 16'h0000;
			wr_left_reg <= 6'h00;
			wr_pos_reg  <= 6'h00;
			rd_left_reg <= 6'h00;
		end else if (st_dec) begin
			if (is_mem && has_addr)
				ptr_reg <= c_addr;
			wr_left_reg <= is_mem ? n_wr : 6'h00;
			wr_pos_reg  <= uhr_pkg::HDR_LEN;
			rd_left_reg <= is_mem ? n_rd : 6'h00;
		end else if (wr_go) begin
			ptr_reg     <= ptr_reg + 16'h0001;
			wr_left_reg <= wr_left_reg - 6'h01;
			wr_pos_reg  <= wr_pos_reg + 6'h01;
		end else if (rd_go) begin
			ptr_reg     <= ptr_reg + 16'h0001;
			rd_left_reg <= rd_left_reg - 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mem_we_reg    <= 1'b0;
			mem_re_reg    <= 1'b0;
			re_d_reg      <= 1'b0;
			mem_addr_reg  <= 16'h0000;
			mem_wdata_reg <= 8'h00;
		end else begin
			mem_we_reg <= wr_go;
			mem_re_reg <= rd_go;
			re_d_reg   <= mem_re_reg;
			if (wr_go || rd_go)
				mem_addr_reg <= ptr_reg;
			if (wr_go)
				mem_wdata_reg <= pkt_byte(cmd_reg, rx_cnt_reg, int'(wr_pos_reg));
		end
	end

	// packet image; read data lands two edges after its strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_img_reg  <= '0;
			rd_slot_reg <= 6'h00;
		end else if (launch) begin
			tx_img_reg <= src_img;
		end else if (st_dec) begin
			tx_img_reg  <= rsp_img;
			rd_slot_reg <= uhr_pkg::RD_BASE;
		end else if (re_d_reg) begin
			tx_img_reg[rd_slot_reg] <= mem_rdata;
			rd_slot_reg             <= rd_slot_reg + 6'h01;
		end
	end

	// first tx cycle only loads byte 0, so the data out stays a flop
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_valid_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
			tx_last_reg  <= 1'b0;
			tx_idx_reg   <= 6'h00;
		end else if (st_tx && !tx_valid_reg) begin
			tx_valid_reg <= 1'b1;
			tx_data_reg  <= tx_img_reg[0];
			tx_idx_reg   <= 6'h00;
		end else if (tx_done) begin
			tx_valid_reg <= 1'b0;
			tx_last_reg  <= 1'b0;
		end else if (tx_beat) begin
			tx_idx_reg  <= tx_idx_reg + 6'h01;
			tx_data_reg <= tx_img_reg[tx_idx_reg + 6'h01];
			tx_last_reg <= (tx_idx_reg + 6'h01 == uhr_pkg::PKT_LAST);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b)
			tx_ep_reg <= uhr_pkg::EP_RSP;
		else if (launch)
			tx_ep_reg <= src_ep;
		else if (st_dec)
			tx_ep_reg <= uhr_pkg::EP_RSP;
	end

	// modes; reserved bytes of the auto-return command are not checked
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			auto_reg   <= 1'b0;
			dbg_on_reg <= 1'b0;
			dbg_id_reg <= uhr_pkg::RID_MEM;
		end else if (st_dec) begin
			if (c_cmd == uhr_pkg::CMD_NULL)
				auto_reg <= 1'b0;
			if (c_cmd == uhr_pkg::CMD_AUTO)
				auto_reg <= 1'b1;
			if (c_cmd == uhr_pkg::CMD_DBG_GO) begin
				dbg_on_reg <= 1'b1;
				dbg_id_reg <= c_id;
				if (c_id == uhr_pkg::RID_MEM)
					auto_reg <= 1'b0;
			end
			if (c_cmd == uhr_pkg::CMD_DBG_STOP)
				dbg_on_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			time_reg      <= 16'h0000;
			tch_taken_reg <= 1'b0;
			sty_taken_reg <= 1'b0;
			msg_taken_reg <= 1'b0;
			dbg_taken_reg <= 1'b0;
		end else begin
			if (launch && sel_tch && tch_first)
				time_reg <= tch_time;
			tch_taken_reg <= launch & sel_tch;
			sty_taken_reg <= launch & sel_sty;
			msg_taken_reg <= launch & sel_msg;
			dbg_taken_reg <= launch & sel_dbg;
		end
	end

	assign rx_ready       = rx_ready_reg;
	assign tx_valid       = tx_valid_reg;
	assign tx_data        = tx_data_reg;
	assign tx_last        = tx_last_reg;
	assign tx_ep          = tx_ep_reg;
	assign mem_addr       = mem_addr_reg;
	assign mem_wdata      = mem_wdata_reg;
	assign mem_we         = mem_we_reg;
	assign mem_re         = mem_re_reg;
	assign tch_taken      = tch_taken_reg;
	assign sty_taken      = sty_taken_reg;
	assign msg_taken      = msg_taken_reg;
	assign dbg_taken      = dbg_taken_reg;
	assign auto_return_on = auto_reg;
	assign debug_mon_on   = dbg_on_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_dec_mem;
		st_dec && is_mem;
	endsequence
	sequence s_msg_pick;
		launch && sel_msg;
	endsequence
	sequence s_msg_out;
		msg_taken_reg && st_tx ##1 tx_valid_reg && tx_ep_reg == uhr_pkg::EP_RSP;
	endsequence

	chk_mem_status: assert property (
		s_dec_mem |=> tx_img_reg[1] == ((tx_img_reg[2] == 8'h00) ? 8'h04 : 8'h00))
		else $error("memory status byte wrong");
	chk_wr_step: assert property (
		mem_we_reg && $past(mem_we_reg) |-> mem_addr_reg == $past(mem_addr_reg) + 16'h0001)
		else $error("write address did not step by one");
	chk_rd_step: assert property (
		mem_re_reg && $past(mem_re_reg) |-> mem_addr_reg == $past(mem_addr_reg) + 16'h0001)
		else $error("read address did not step by one");
	chk_null_stop: assert property (
		st_dec && c_cmd == 8'h00 |=> !auto_reg)
		else $error("null command left auto-return on");
	chk_dbg_start: assert property (
		st_dec && c_cmd == uhr_pkg::CMD_DBG_GO && c_id == 8'h01 |=> dbg_on_reg && !auto_reg)
		else $error("debug start with id one mishandled");
	chk_dbg_stop: assert property (
		st_dec && c_cmd == uhr_pkg::CMD_DBG_STOP |=> !dbg_on_reg ##[1:3] tx_valid_reg)
		else $error("debug stop not obeyed or not answered");
	chk_msg_send: assert property (
		s_msg_pick |=> s_msg_out)
		else $error("message packet not sent on endpoint one");
	chk_one_rsp: assert property (
		st_dec |-> ##[1:200] (tx_valid_reg && tx_ep_reg == 4'h1))
		else $error("no response packet for command");
	chk_pkt_len: assert property (
		tx_done |-> tx_idx_reg == 6'h3f)
		else $error("packet not 64 bytes");
	chk_sty_id: assert property (
		launch && sel_sty |=> tx_img_reg[0] == 8'h03 && tx_img_reg[1][7:5] == 3'h0)
		else $error("stylus report header wrong");
	chk_tch_msb: assert property (
		launch && sel_tch |=> tx_img_reg[3][7:4] == 4'h0 && tx_img_reg[7][7:4] == 4'h0)
		else $error("touch position msb nibble not zero");
	chk_tch_cnt: assert property (
		launch && sel_tch && !tch_first |=> tx_img_reg[58] == 8'h00)
		else $error("contact count not zero after first packet");
endmodule
`default_nettype wire

// ### dv/uhr_host.sv
// usb host model: sends command packets, collects answer packets
`timescale 1ns/1ps
`default_nettype none
module uhr_host (
	input  wire logic       mclk,
	input  wire logic       rx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last,
	output logic [3:0]      rx_ep,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	input  wire logic [3:0] tx_ep,
	output logic            tx_ready
);
	logic [7:0] c [64];
	logic [7:0] p [64];
	logic [3:0] p_ep;
	logic       slow = 1'b0;
	logic       hung = 1'b0;
	logic [1:0] cnt = 2'h0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		rx_ep = 4'h0;
	end
	always @(posedge mclk) cnt <= cnt + 2'h1;
	// slow mode takes one byte in four
	assign tx_ready = !slow || cnt == 2'h0;
	task automatic send();
		int k;
		for (int i = 0; i < 64; i++) begin
			rx_valid <= 1'b1;
			rx_data <= c[i];
			rx_last <= (i == 63);
			rx_ep <= uhr_pkg::EP_CMD;
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (rx_ready !== 1'b1 && k < 500);
			if (k >= 500) hung = 1'b1;
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		// released lines never keep the last byte
		rx_data <= ~rx_data;
		rx_ep <= 4'h0;
	endtask
	task automatic recv();
		int k;
		for (int i = 0; i < 64; i++) begin
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (!(tx_valid === 1'b1 && tx_ready) && k < 500);
			p[i] = tx_data;
			if (k >= 500 || tx_last !== (i == 63)) hung = 1'b1;
		end
		p_ep = tx_ep;
	endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// bench: command, message, debug and report packets
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk = 1'b0, rst_b = 1'b0;
	logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	logic [7:0] rx_data, tx_data, mem_wdata, ahi, mem_rdata = 8'h00;
	logic [3:0] rx_ep, tx_ep;
	logic [15:0] mem_addr;
	logic mem_we, mem_re, auto_return_on, debug_mon_on;
	logic tch_taken, sty_taken, msg_taken, dbg_taken;
	logic geometry_calc_enable = 1'b0, tch_valid = 1'b0, tch_first = 1'b1;
	logic sty_valid = 1'b0, msg_valid = 1'b0, dbg_valid = 1'b0;
	logic [7:0] tch_count = 8'h02, sty_prs = 8'h4d, object_report_identifier = 8'h2a;
	logic [7:0] debug_packet_index = 8'h01, debug_packet_total = 8'h03;
	logic [7:0] debug_frame_number = 8'h09;
	logic [15:0] tch_time = 16'h1234, sty_x = 16'h0abc, sty_xc = 16'h0def, sty_y = 16'h0123;
	logic [4:0] tch_stat = 5'h01;
	logic [3:0] sty_flags = 4'hb;
	logic [4:0][11:0] tch_x = 60'habc, tch_y = 60'h456;
	logic [4:0][7:0] tch_w = 40'h99;
	logic [9:0][7:0] msg_data = 80'hc3;
	logic [7:0] mem [256];
	int n_fail = 0, checks_done = 0;
	uhr_top i_dut (.mclk, .rst_b, .rx_valid, .rx_data, .rx_last, .rx_ep, .rx_ready,
		.tx_valid, .tx_data, .tx_last, .tx_ep, .tx_ready, .mem_addr, .mem_wdata, .mem_we,
		.mem_re, .mem_rdata, .geometry_calc_enable, .tch_valid, .tch_first, .tch_count,
		.tch_time, .tch_stat, .tch_x, .tch_xc({5{12'h321}}), .tch_y, .tch_yc({5{12'h789}}),
		.tch_w, .tch_h({5{8'h66}}), .tch_taken, .sty_valid, .sty_flags, .sty_x, .sty_xc, .sty_y,
		.sty_yc(16'h5a5a),
		.sty_prs, .sty_taken, .msg_valid, .object_report_identifier, .msg_data, .msg_taken,
		.dbg_valid, .debug_packet_index, .debug_packet_total, .debug_frame_number,
		.dbg_data({59{8'h77}}), .dbg_taken, .auto_return_on, .debug_mon_on);
	uhr_host i_host (.mclk, .rx_ready, .rx_valid, .rx_data, .rx_last, .rx_ep,
		.tx_valid, .tx_data, .tx_last, .tx_ep, .tx_ready);
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
		if (mem_we | mem_re) ahi <= mem_addr[15:8];
		mem_rdata <= mem_re ? mem[mem_addr[7:0]] : ~mem_rdata;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic fin();
		chk("hang", {7'h0, i_host.hung}, 8'h00);
		if (i_host.hung !== 1'b0) report_and_stop();
	endtask
	// header bytes low first; unlisted bytes go out as zero
	task automatic cmd(input logic [95:0] h);
		for (int i = 0; i < 64; i++) i_host.c[i] = (i < 12) ? h[8*i+:8] : 8'h00;
		i_host.send();
		i_host.recv();
		fin();
		chk("ep", {4'h0, i_host.p_ep}, {4'h0, uhr_pkg::EP_RSP});
		chk("id", i_host.p[0], h[7:0]);
	endtask
	task automatic take();
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while ((tch_taken | sty_taken | msg_taken | dbg_taken) !== 1'b1 && k < 500);
		if (k >= 500) i_host.hung = 1'b1;
		tch_valid <= 1'b0;
		sty_valid <= 1'b0;
		msg_valid <= 1'b0;
		dbg_valid <= 1'b0;
		i_host.recv();
		fin();
	endtask
	initial begin
		logic [95:0] e;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		// four bytes at 0x1234, a stray byte past the count
		cmd(96'h00ee_a3a2_a1a0_1234_0600_0101);
		chk("st", i_host.p[1], uhr_pkg::ST_WR_ONLY);
		for (int i = 0; i < 4; i++) chk("wr", mem[8'h34+i], 8'ha0 + 8'(i));
		chk("stray", mem[8'h38], 8'h62);
		chk("ahi", ahi, 8'h12);
		i_host.slow = 1'b1;
		cmd(96'h1234_0204_0101);
		chk("st", i_host.p[1], uhr_pkg::ST_OK);
		chk("nrx", i_host.p[2], 8'h04);
		for (int i = 0; i < 4; i++) chk("rd", i_host.p[3+i], 8'ha0 + 8'(i));
		cmd(96'h0002_0101);
		chk("seq", i_host.p[3], 8'h62);
		chk("seq", i_host.p[4], 8'h63);
		i_host.slow = 1'b0;
		cmd(96'h0201);
		chk("auto", {7'h0, auto_return_on}, 8'h01);
		msg_valid <= 1'b1;
		take();
		e = 96'hc3_2a_05_01;
		for (int i = 0; i < 4; i++) chk("msg", i_host.p[i], e[8*i+:8]);
		cmd(96'h0001);
		chk("null", {7'h0, auto_return_on}, 8'h00);
		cmd(96'h0302);
		chk("dbg", {7'h0, debug_mon_on}, 8'h01);
		dbg_valid <= 1'b1;
		take();
		e = 96'h77_09_03_01_06_02;
		for (int i = 0; i < 6; i++) chk("dpk", i_host.p[i], e[8*i+:8]);
		chk("dep", {4'h0, i_host.p_ep}, {4'h0, uhr_pkg::EP_RSP});
		cmd(96'h0201);
		cmd(96'h0301);
		chk("auto", {7'h0, auto_return_on}, 8'h00);
		cmd(96'h0402);
		chk("stop", i_host.p[1], uhr_pkg::CMD_DBG_STOP);
		chk("stop", {7'h0, debug_mon_on}, 8'h00);
		sty_valid <= 1'b1;
		take();
		e = 96'h4d_5a5a_0123_0def_0abc_13_03;
		for (int i = 0; i < 11; i++) chk("sty", i_host.p[i], e[8*i+:8]);
		tch_valid <= 1'b1;
		take();
		e = 96'h0000_0000_0456_0000_0abc_0901;
		for (int i = 0; i < 12; i++) chk("tch", i_host.p[i], e[8*i+:8]);
		chk("id2", i_host.p[12], 8'h10);
		chk("cnt", i_host.p[58], 8'h02);
		chk("time", i_host.p[56], 8'h34);
		tch_first <= 1'b0;
		tch_time <= 16'h5678;
		geometry_calc_enable <= 1'b1;
		tch_valid <= 1'b1;
		take();
		chk("cnt", i_host.p[58], 8'h00);
		chk("time", i_host.p[57], 8'h12);
		// geometry on: centre, width and height bytes now filled
		e = 96'h66_99_0789_0456_0321_0abc_09_01;
		for (int i = 0; i < 12; i++) chk("geo", i_host.p[i], e[8*i+:8]);
		chk("wid", i_host.p[10], 8'h99);
		report_and_stop();
	end
endmodule
`default_nettype wire
